/* src/fcm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Flash code: 93.75 mA per step, zero=93.75
// - Down threshold code: 2.9 V plus 0.1 V
// - Below threshold during flash in hold mode: freeze ramp level
// - Threshold crossing in hold mode sets flag
// - Lockout enabled and supply low: enter standby
// - Each lockout standby sets the undervoltage flag
// - Lockout enable bit 7, resets enabled
// - Hold mode only when enable bit seven set
// - Fault held until flags read; re-set if present
module fcm_monitor
    import fcm_pkg::*;
(
    input wire logic mclk, // 25 MHz clock
    input wire logic nrst, // Async reset, active low
    input wire logic [7:0] reg_addr, // Register address from serial block
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_we, // Write strobe, one cycle
    input wire logic reg_re, // Read strobe, one cycle
    output logic [7:0] reg_rdata_r, // Read data, valid cycle after reg_re
    input wire logic hold_mode_en, // Enable register bit 7 (stop-and-hold)
    input wire logic flash_active, // Flash pulse in progress
    input wire logic ramp_step, // Ramp timer tick, one cycle
    input wire logic flags_read, // Flags register read back, one cycle
    input wire logic vin_below_down, // Comparator pin: supply below down threshold
    input wire logic vin_below_undervoltage_lockout, // Comparator pin: supply below 2.8 V
    output logic [3:0] flash_code_r, // Flash current target code
    output logic [2:0] torch_code_r, // Torch current code
    output logic [2:0] down_thr_code_r, // Down threshold code to comparator DAC
    output logic undervoltage_lockout_enable_r, // Lockout enable
    output logic [3:0] flash_level_r, // Present ramp level
    output logic ramp_hold_r, // Ramp frozen
    output logic force_standby_r, // Lockout forces standby
    output logic monitor_flag_set_r, // Pulse: set monitor flag
    output logic undervoltage_lockout_flag_set_r // Pulse: set undervoltage flag
);

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for the analog comparator pins
    logic down_s1_r, down_s2_r, down_d_r; // Down comparator chain
    logic uv_s1_r, uv_s2_r; // Lockout comparator chain
    logic down_fall; // Supply just crossed below threshold

    // Only the second stage and the down edge-detect delay flop are read by logic
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            down_s1_r <= 1'b0;
            down_s2_r <= 1'b0;
            down_d_r <= 1'b0;
            uv_s1_r <= 1'b0;
            uv_s2_r <= 1'b0;
        end
        else
        begin
            down_s1_r <= vin_below_down;
            down_s2_r <= down_s1_r;
            down_d_r <= down_s2_r;
            uv_s1_r <= vin_below_undervoltage_lockout;
            uv_s2_r <= uv_s1_r;
        end
    end

    assign down_fall = down_s2_r && !down_d_r;

    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0] cur_nxt, mon_nxt, rd_nxt; // Next register values
    logic [7:0] cur_r, mon_r; // Stored registers

    // Writes keep only the defined fields; reserved bits are kept zero so they read back zero
    always_comb
    begin
        cur_nxt = cur_r;
        mon_nxt = mon_r;
        rd_nxt = reg_rdata_r;
        if (reg_we && reg_addr == FCM_LED_CURRENT_CONTROL_ADDR)
        begin
            cur_nxt = {1'b0, reg_wdata[FCM_TORCH_LSB +: FCM_TORCH_W],
                       reg_wdata[FCM_FLASH_LSB +: FCM_FLASH_W]};
        end
        if (reg_we && reg_addr == FCM_MONITOR_CONFIG_ADDR)
        begin
            mon_nxt = 8'h00;
            mon_nxt[FCM_UNDERVOLTAGE_LOCKOUT_ENABLE_BIT] = reg_wdata[FCM_UNDERVOLTAGE_LOCKOUT_ENABLE_BIT];
            mon_nxt[FCM_THR_LSB +: FCM_THR_W] = reg_wdata[FCM_THR_LSB +: FCM_THR_W];
        end
        if (reg_re)
        begin
            // Unmapped addresses answer zero
            unique case (reg_addr)
                FCM_LED_CURRENT_CONTROL_ADDR: rd_nxt = cur_r;
                FCM_MONITOR_CONFIG_ADDR: rd_nxt = mon_r;
                default: rd_nxt = FCM_UNMAPPED_DATA;
            endcase
        end
    end

    // Register stage
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            cur_r <= FCM_LED_CURRENT_CONTROL_RST;
            mon_r <= FCM_MONITOR_CONFIG_RST;
            reg_rdata_r <= FCM_UNMAPPED_DATA;
        end
        else
        begin
            cur_r <= cur_nxt;
            mon_r <= mon_nxt;
            reg_rdata_r <= rd_nxt;
        end
    end

    // Field outputs follow the stored registers, all from flops
    assign flash_code_r = cur_r[FCM_FLASH_LSB +: FCM_FLASH_W];
    assign torch_code_r = cur_r[FCM_TORCH_LSB +: FCM_TORCH_W];
    assign down_thr_code_r = mon_r[FCM_THR_LSB +: FCM_THR_W];
    assign undervoltage_lockout_enable_r = mon_r[FCM_UNDERVOLTAGE_LOCKOUT_ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Ramp, hold and lockout
    logic [3:0] level_nxt; // Next ramp level
    logic hold_nxt, stby_nxt, mflag_nxt, uflag_nxt; // Next control values
    logic uv_trip; // Lockout condition seen this cycle

    // Lockout is a level so a restart with the supply still low re-trips
    assign uv_trip = undervoltage_lockout_enable_r && uv_s2_r;

    always_comb
    begin
        level_nxt = flash_level_r;
        hold_nxt = ramp_hold_r;
        stby_nxt = force_standby_r;
        // Flag pulses fire on each new event
        mflag_nxt = down_fall && hold_mode_en;
        // A flags read that finds the lockout still present must see the flag come back
        uflag_nxt = uv_trip && (!force_standby_r || flags_read);
        // Standby stays until software reads flags; a new trip wins the clear
        if (uv_trip)
            stby_nxt = 1'b1;
        else if (flags_read)
            stby_nxt = 1'b0;
        if (!flash_active || stby_nxt)
        begin
            // Outside a flash the ramp restarts from the bottom
            level_nxt = FCM_LEVEL_ZERO;
            hold_nxt = 1'b0;
        end
        else
        begin
            // Freeze for the rest of this flash once the supply sags
            if (hold_mode_en && down_fall)
                hold_nxt = 1'b1;
            if (ramp_step && !hold_nxt && flash_level_r < flash_code_r)
                level_nxt = flash_level_r + FCM_LEVEL_ONE;
        end
    end

    // Register stage
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            flash_level_r <= FCM_LEVEL_ZERO;
            ramp_hold_r <= 1'b0;
            force_standby_r <= 1'b0;
            monitor_flag_set_r <= 1'b0;
            undervoltage_lockout_flag_set_r <= 1'b0;
        end
        else
        begin
            flash_level_r <= level_nxt;
            ramp_hold_r <= hold_nxt;
            force_standby_r <= stby_nxt;
            monitor_flag_set_r <= mflag_nxt;
            undervoltage_lockout_flag_set_r <= uflag_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_level_frozen: assert property (@(posedge mclk) disable iff (!nrst)
        ramp_hold_r && $past(ramp_hold_r) |-> flash_level_r == $past(flash_level_r))
        else $error("ramp level moved while held");
    a_level_bound: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(flash_level_r[0]) || $changed(flash_level_r) && flash_level_r != FCM_LEVEL_ZERO
        |-> flash_level_r <= flash_code_r)
        else $error("ramp level passed flash target");
    a_hold_needs_en: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(ramp_hold_r) |-> $past(hold_mode_en))
        else $error("hold without mode enable");
    a_mon_flag: assert property (@(posedge mclk) disable iff (!nrst)
        down_s2_r && !down_d_r && hold_mode_en |=> monitor_flag_set_r)
        else $error("monitor flag not set on crossing");
    a_uv_standby: assert property (@(posedge mclk) disable iff (!nrst)
        undervoltage_lockout_enable_r && uv_s2_r |=> force_standby_r ##1 flash_level_r == FCM_LEVEL_ZERO)
        else $error("lockout did not force standby");
    a_uv_flag: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(force_standby_r) |-> undervoltage_lockout_flag_set_r)
        else $error("standby without lockout flag");
    a_uv_disabled: assert property (@(posedge mclk) disable iff (!nrst)
        !undervoltage_lockout_enable_r && !force_standby_r |=> !force_standby_r)
        else $error("standby while lockout disabled");
    a_fault_held: assert property (@(posedge mclk) disable iff (!nrst)
        force_standby_r && !flags_read |=> force_standby_r)
        else $error("standby released without flags read");
    a_uv_reflag: assert property (@(posedge mclk) disable iff (!nrst)
        force_standby_r && flags_read && uv_trip |=> force_standby_r && undervoltage_lockout_flag_set_r)
        else $error("persisting lockout not flagged again after flags read");
    a_thr_write: assert property (@(posedge mclk) disable iff (!nrst)
        reg_we && reg_addr == FCM_MONITOR_CONFIG_ADDR
        |=> down_thr_code_r == $past(reg_wdata[FCM_THR_LSB +: FCM_THR_W]) && mon_r[1:0] == 2'h0)
        else $error("threshold field not written");
    a_torch_write: assert property (@(posedge mclk) disable iff (!nrst)
        reg_we && reg_addr == FCM_LED_CURRENT_CONTROL_ADDR
        |=> torch_code_r == $past(reg_wdata[FCM_TORCH_LSB +: FCM_TORCH_W]) && !cur_r[7])
        else $error("torch field not written");

endmodule

`default_nettype wire

/* src/fcm_pkg.sv */
package fcm_pkg;
    // Register offsets on the internal register port
    localparam logic [7:0] FCM_MONITOR_CONFIG_ADDR = 8'h01;
    localparam logic [7:0] FCM_LED_CURRENT_CONTROL_ADDR = 8'h09;
    // Reset values
    localparam logic [7:0] FCM_MONITOR_CONFIG_RST = 8'h80;
    localparam logic [7:0] FCM_LED_CURRENT_CONTROL_RST = 8'h0f;
    // Field positions
    localparam int FCM_FLASH_LSB = 0;
    localparam int FCM_FLASH_W = 4;
    localparam int FCM_TORCH_LSB = 4;
    localparam int FCM_TORCH_W = 3;
    localparam int FCM_THR_LSB = 2;
    localparam int FCM_THR_W = 3;
    localparam int FCM_UNDERVOLTAGE_LOCKOUT_ENABLE_BIT = 7;
    // Analog meaning of the codes, for reference by the analog side
    localparam int FCM_FLASH_STEP_UA = 93750;
    localparam int FCM_THR_BASE_MV = 2900;
    localparam int FCM_THR_STEP_MV = 100;
    localparam int FCM_UNDERVOLTAGE_LOCKOUT_MV = 2800;
    // Misc constants
    localparam logic [7:0] FCM_UNMAPPED_DATA = 8'h00;
    localparam logic [3:0] FCM_LEVEL_ZERO = 4'h0;
    localparam logic [3:0] FCM_LEVEL_ONE = 4'h1;
endpackage

/* tb/test_flash_current_input_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module test_flash_current_input_monitor;
    import fcm_pkg::*;
    logic mclk, nrst, reg_we, reg_re, hold_mode_en, flash_active, ramp_step, flags_read;
    logic vin_below_down, vin_below_undervoltage_lockout, undervoltage_lockout_enable_r, ramp_hold_r, force_standby_r;
    logic monitor_flag_set_r, undervoltage_lockout_flag_set_r, seen;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_r;
    logic [3:0] flash_code_r, flash_level_r;
    logic [2:0] torch_code_r, down_thr_code_r;
    int mismatches = 0; // Failed comparisons
    int cmp_count = 0; // All comparisons
    // Rows: address, write data, expected read-back; reserved bits must read zero
    logic [23:0] rows [6] = '{24'h01ff9c, 24'h09ff7f, 24'h05ff00, 24'h097a7a, 24'h010000, 24'h018c8c};
    fcm_monitor dut_u (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata_r,
        .hold_mode_en, .flash_active, .ramp_step, .flags_read, .vin_below_down, .vin_below_undervoltage_lockout,
        .flash_code_r, .torch_code_r, .down_thr_code_r, .undervoltage_lockout_enable_r, .flash_level_r, .ramp_hold_r,
        .force_standby_r, .monitor_flag_set_r, .undervoltage_lockout_flag_set_r);
    ////////////////////////////////////////////////////////////////
    // 40 ns clock
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Inputs always move 1 ns after the edge, so the edge samples settled values
    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a; reg_wdata = d; reg_we = 1'b1;
        tick(1);
        reg_we = 1'b0;
    endtask
    task rd_cmp(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a; reg_re = 1'b1;
        tick(1);
        reg_re = 1'b0;
        cmp(reg_rdata_r, exp);
    endtask
    task step(input int n);
        ramp_step = 1'b1;
        tick(n);
        ramp_step = 1'b0;
    endtask
    // Comparator paths are synchronised, so watch a bounded span for the pulse
    task wait_flag(input bit uv);
        seen = 1'b0;
        repeat (6)
        begin
            tick(1);
            seen = seen | (uv ? undervoltage_lockout_flag_set_r : monitor_flag_set_r);
        end
    endtask
    task final_report;
        $display("comparisons=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog sized well above the expected run of about 85 cycles
    initial
    begin
        #80000;
        mismatches++;
        final_report;
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        {reg_we, reg_re, hold_mode_en, flash_active, ramp_step, flags_read} = '0;
        {vin_below_down, vin_below_undervoltage_lockout, reg_addr, reg_wdata} = '0;
        nrst = 1'b0;
        tick(6);
        nrst = 1'b1;
        cmp({1'b0, torch_code_r, flash_code_r}, FCM_LED_CURRENT_CONTROL_RST);
        cmp({undervoltage_lockout_enable_r, 2'b00, down_thr_code_r, 2'b00}, FCM_MONITOR_CONFIG_RST);
        rd_cmp(8'h09, 8'h0f);
        $display("reset test done");
        foreach (rows[i])
        begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd_cmp(rows[i][23:16], rows[i][7:0]);
        end
        cmp({1'b0, torch_code_r, flash_code_r}, 8'h7a);
        cmp({undervoltage_lockout_enable_r, 2'b00, down_thr_code_r, 2'b00}, 8'h8c);
        $display("register rows done");
        // Ramp stops at the programmed code
        wr(8'h09, 8'h03);
        flash_active = 1'b1;
        tick(1);
        step(6);
        cmp(flash_level_r, 8'h03);
        flash_active = 1'b0;
        tick(1);
        cmp(flash_level_r, 8'h00);
        wr(8'h09, 8'h0a);
        hold_mode_en = 1'b1;
        flash_active = 1'b1;
        tick(1);
        step(2);
        vin_below_down = 1'b1;
        wait_flag(1'b0);
        cmp(seen, 8'h01);
        cmp(ramp_hold_r, 8'h01);
        step(3);
        cmp(flash_level_r, 8'h02);
        flash_active = 1'b0;
        vin_below_down = 1'b0;
        tick(2);
        cmp({ramp_hold_r, flash_level_r}, 8'h00);
        // Mode off: the same sag inside a flash neither flags nor freezes the ramp
        hold_mode_en = 1'b0;
        flash_active = 1'b1;
        tick(4);
        vin_below_down = 1'b1;
        wait_flag(1'b0);
        cmp(seen, 8'h00);
        step(3);
        cmp({ramp_hold_r, flash_level_r}, 8'h03);
        flash_active = 1'b0;
        vin_below_down = 1'b0;
        $display("hold test done");
        vin_below_undervoltage_lockout = 1'b1;
        wait_flag(1'b1);
        cmp(seen, 8'h01);
        cmp(force_standby_r, 8'h01);
        vin_below_undervoltage_lockout = 1'b0;
        tick(4);
        cmp(force_standby_r, 8'h01);
        flags_read = 1'b1;
        tick(1);
        flags_read = 1'b0;
        tick(1);
        cmp(force_standby_r, 8'h00);
        wr(8'h01, 8'h00);
        vin_below_undervoltage_lockout = 1'b1;
        wait_flag(1'b1);
        cmp({seen, force_standby_r}, 8'h00);
        $display("lockout test done");
        // Mid-run reset with the supply still low: lockout comes back enabled and re-trips
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        cmp({1'b0, torch_code_r, flash_code_r}, FCM_LED_CURRENT_CONTROL_RST);
        cmp({undervoltage_lockout_enable_r, 2'b00, down_thr_code_r, 2'b00}, FCM_MONITOR_CONFIG_RST);
        wait_flag(1'b1);
        cmp({seen, force_standby_r}, 8'h03);
        // A flags read while the fault persists keeps standby and sets the flag again
        flags_read = 1'b1;
        tick(1);
        flags_read = 1'b0;
        cmp({undervoltage_lockout_flag_set_r, force_standby_r}, 8'h03);
        $display("restart test done");
        final_report;
    end
endmodule
`default_nettype wire
